/* logic/rss_regs.sv */
// Rail strobe assignment registers with step match for four outputs.
//
// Design decision made here: the plain strobed port.
`timescale 1ns/10ps
module rss_regs (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out,
  input wire logic password_ok_in,
  input wire logic [7:0] nv_switch_ldo_in,
  input wire logic [7:0] nv_gpo_in,
  input wire logic factory_seal_flag_in,
  input wire logic [3:0] strobe_step_in,
  input wire logic strobe_valid_in,
  input wire logic seq_clear_in,
  output logic write_refused_out,
  output logic nv_loaded_out,
  output logic backup_step_allowed_out,
  output logic low_voltage_load_switch_en_out,
  output logic general_linear_regulator_en_out,
  output logic third_general_output_en_out,
  output logic first_general_output_en_out,
  output logic [3:0] controlled_out
);
  import rss_pkg::*;

  // ----------------------------------------
  // Register state
  // ----------------------------------------
  logic [7:0] switch_ldo_strobe_select_reg;
  logic [7:0] switch_ldo_strobe_select_next;
  logic [7:0] gpo_strobe_select_reg;
  logic [7:0] gpo_strobe_select_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic refused_reg;
  logic refused_next;
  rss_state_type state_reg;
  rss_state_type state_next;
  logic [7:0] load_cnt_reg;
  logic [7:0] load_cnt_next;
  logic seal_sync;

  rss_sync u_seal_sync (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .d_in(factory_seal_flag_in),
    .q_out(seal_sync)
  );

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    switch_ldo_strobe_select_next = switch_ldo_strobe_select_reg;
    gpo_strobe_select_next = gpo_strobe_select_reg;
    rdata_next = 8'h00;
    refused_next = 1'b0;
    state_next = state_reg;
    load_cnt_next = load_cnt_reg;
    case (state_reg)
      RSS_LOADING:
      begin
        switch_ldo_strobe_select_next = nv_switch_ldo_in;
        gpo_strobe_select_next = nv_gpo_in;
        if (load_cnt_reg >= 8'(RSS_NV_LOAD_CYCLES - 1))
          state_next = RSS_RUN;
        else
          load_cnt_next = load_cnt_reg + 8'h01;
      end
      RSS_RUN:
      begin
        if (wr_in)
        begin
          if (!password_ok_in)
            refused_next = 1'b1;
          else if (addr_in == RSS_SWITCH_LDO_ADDR)
          begin
            switch_ldo_strobe_select_next[RSS_HI_MSB:RSS_HI_LSB] = wdata_in[RSS_HI_MSB:RSS_HI_LSB];
            switch_ldo_strobe_select_next[RSS_LO_MSB:RSS_LO_LSB] = wdata_in[RSS_LO_MSB:RSS_LO_LSB];
          end
          else if (addr_in == RSS_GPO_ADDR)
          begin
            gpo_strobe_select_next[RSS_HI_MSB:RSS_HI_LSB] = wdata_in[RSS_HI_MSB:RSS_HI_LSB];
            gpo_strobe_select_next[RSS_LO_MSB:RSS_LO_LSB] = wdata_in[RSS_LO_MSB:RSS_LO_LSB];
          end
        end
      end
      default:
        state_next = RSS_LOADING;
    endcase
    if (rd_in)
    begin
      if (addr_in == RSS_SWITCH_LDO_ADDR)
        rdata_next = switch_ldo_strobe_select_reg;
      else if (addr_in == RSS_GPO_ADDR)
        rdata_next = gpo_strobe_select_reg;
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      switch_ldo_strobe_select_reg <= RSS_SWITCH_LDO_RESET;
      gpo_strobe_select_reg <= RSS_GPO_RESET;
      rdata_reg <= 8'h00;
      refused_reg <= 1'b0;
      state_reg <= RSS_LOADING;
      load_cnt_reg <= 8'h00;
    end
    else
    begin
      switch_ldo_strobe_select_reg <= switch_ldo_strobe_select_next;
      gpo_strobe_select_reg <= gpo_strobe_select_next;
      rdata_reg <= rdata_next;
      refused_reg <= refused_next;
      state_reg <= state_next;
      load_cnt_reg <= load_cnt_next;
    end
  end

  // ----------------------------------------
  // Step matching
  // ----------------------------------------
  logic active;
  assign active = (state_reg == RSS_RUN) && strobe_valid_in;

  rss_step_match u_switch (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .sel_in(switch_ldo_strobe_select_reg[RSS_HI_MSB:RSS_HI_LSB]),
    .step_in(strobe_step_in),
    .step_valid_in(active),
    .clear_in(seq_clear_in),
    .enable_out(low_voltage_load_switch_en_out),
    .controlled_out(controlled_out[3])
  );
  rss_step_match u_ldo (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .sel_in(switch_ldo_strobe_select_reg[RSS_LO_MSB:RSS_LO_LSB]),
    .step_in(strobe_step_in),
    .step_valid_in(active),
    .clear_in(seq_clear_in),
    .enable_out(general_linear_regulator_en_out),
    .controlled_out(controlled_out[2])
  );
  rss_step_match u_third_general_output (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .sel_in(gpo_strobe_select_reg[RSS_HI_MSB:RSS_HI_LSB]),
    .step_in(strobe_step_in),
    .step_valid_in(active),
    .clear_in(seq_clear_in),
    .enable_out(third_general_output_en_out),
    .controlled_out(controlled_out[1])
  );
  rss_step_match u_first_general_output (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .sel_in(gpo_strobe_select_reg[RSS_LO_MSB:RSS_LO_LSB]),
    .step_in(strobe_step_in),
    .step_valid_in(active),
    .clear_in(seq_clear_in),
    .enable_out(first_general_output_en_out),
    .controlled_out(controlled_out[0])
  );

  assign backup_step_allowed_out = !seal_sync && strobe_valid_in && (strobe_step_in != 4'h0)
    && (strobe_step_in <= RSS_SEAL_STEP_MAX);
  assign rdata_out = rdata_reg;
  assign write_refused_out = refused_reg;
  assign nv_loaded_out = (state_reg == RSS_RUN);
endmodule

/* logic/rss_pkg.sv */
// Package of constants and types for the rail strobe assignment registers.
// Operation
// - The first sequence register holds the load switch step select in bits 7 to 4, resetting to Ah.
// - The first sequence register holds the linear regulator step select in bits 3 to 0, resetting to 7h.
// - A step select code from 3h to Ah switches its output on at the strobe step equal to that code.
// - Codes 0h to 2h and Bh to Fh leave the output outside sequencer control.
// - The second sequence register sits at subaddress 26h and resets to 35h.
// - Bits 7 to 4 of the second sequence register select the step of the third general output, resetting to 3h.
// - Bits 3 to 0 of the second sequence register select the step of the first general output, resetting to 5h.
// - Writes to the sequence registers take effect only once the register password has been supplied.
// - Strobe steps 1 and 2 run only while the factory seal flag is zero and belong to the backup converters.
package rss_pkg;
  localparam logic [7:0] RSS_SWITCH_LDO_ADDR = 8'h25;
  localparam logic [7:0] RSS_GPO_ADDR = 8'h26;
  localparam logic [7:0] RSS_SWITCH_LDO_RESET = 8'ha7;
  localparam logic [7:0] RSS_GPO_RESET = 8'h35;
  localparam int RSS_HI_MSB = 7;
  localparam int RSS_HI_LSB = 4;
  localparam int RSS_LO_MSB = 3;
  localparam int RSS_LO_LSB = 0;
  localparam logic [3:0] RSS_STEP_MIN = 4'h3;
  localparam logic [3:0] RSS_STEP_MAX = 4'ha;
  localparam logic [3:0] RSS_SEAL_STEP_MAX = 4'h2;
  localparam int RSS_NV_LOAD_NS = 40;
  localparam int RSS_CLK_NS = 10;
  localparam int RSS_NV_LOAD_CYCLES = (RSS_NV_LOAD_NS + RSS_CLK_NS - 1) / RSS_CLK_NS;
  typedef enum logic [1:0] {RSS_LOADING, RSS_RUN} rss_state_type;
endpackage

/* logic/rss_sync.sv */
// Two flip-flop synchroniser for a level from outside the clock domain.
`timescale 1ns/10ps
module rss_sync (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic d_in,
  output logic q_out
);
  logic meta_reg;
  logic q_reg;
  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      meta_reg <= 1'b0;
      q_reg <= 1'b0;
    end
    else
    begin
      meta_reg <= d_in;
      q_reg <= meta_reg;
    end
  end
  assign q_out = q_reg;
endmodule

/* logic/rss_step_match.sv */
// Compares one step select field against the running strobe step.
`timescale 1ns/10ps
module rss_step_match (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic [3:0] sel_in,
  input wire logic [3:0] step_in,
  input wire logic step_valid_in,
  input wire logic clear_in,
  output logic enable_out,
  output logic controlled_out
);
  import rss_pkg::*;
  logic enable_reg;
  logic enable_next;
  logic controlled;
  assign controlled = (sel_in >= RSS_STEP_MIN) && (sel_in <= RSS_STEP_MAX);
  always_comb
  begin
    enable_next = enable_reg;
    if (clear_in || !controlled)
      enable_next = 1'b0;
    else if (step_valid_in && step_in == sel_in)
      enable_next = 1'b1;
  end
  always_ff @(posedge clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      enable_reg <= 1'b0;
    else
      enable_reg <= enable_next;
  end
  assign enable_out = enable_reg;
  assign controlled_out = controlled;
endmodule

/* verification/rss_regs_checker.sv */
// Checker of the rail strobe assignment register block.
`timescale 1ns/10ps
module rss_regs_checker (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [7:0] rdata_out,
  input wire logic password_ok_in,
  input wire logic factory_seal_flag_in,
  input wire logic [3:0] strobe_step_in,
  input wire logic strobe_valid_in,
  input wire logic seq_clear_in,
  input wire logic write_refused_out,
  input wire logic nv_loaded_out,
  input wire logic backup_step_allowed_out,
  input wire logic low_voltage_load_switch_en_out,
  input wire logic first_general_output_en_out,
  input wire logic [3:0] controlled_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  property p_refuse; wr_in && !password_ok_in && nv_loaded_out |=> write_refused_out; endproperty
  a_refuse: assert property (p_refuse) else $error("refused write gave no pulse");
  property p_rd_idle; !rd_in |=> rdata_out == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data without a read");
  property p_backup; backup_step_allowed_out |-> strobe_valid_in && strobe_step_in inside {4'h1, 4'h2}; endproperty
  a_backup: assert property (p_backup) else $error("backup step outside steps 1 and 2");
  property p_seal; factory_seal_flag_in [*4] |-> !backup_step_allowed_out; endproperty
  a_seal: assert property (p_seal) else $error("backup step with seal flag set");
  property p_first_general_output; $rose(first_general_output_en_out) |-> $past(strobe_valid_in) && $past(controlled_out[0]); endproperty
  a_first_general_output: assert property (p_first_general_output) else $error("first output enabled without cause");
  property p_ls; $rose(low_voltage_load_switch_en_out) |-> $past(strobe_valid_in) && $past(controlled_out[3]); endproperty
  a_ls: assert property (p_ls) else $error("load switch enabled without cause");
  property p_clear; seq_clear_in |=> !low_voltage_load_switch_en_out && !first_general_output_en_out; endproperty
  a_clear: assert property (p_clear) else $error("enable stands after clear");
  property p_loaded; nv_loaded_out |=> nv_loaded_out; endproperty
  a_loaded: assert property (p_loaded) else $error("load done flag fell");
endmodule
bind rss_regs rss_regs_checker chk (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .wr_in(wr_in), .rd_in(rd_in),
  .rdata_out(rdata_out), .password_ok_in(password_ok_in), .factory_seal_flag_in(factory_seal_flag_in),
  .strobe_step_in(strobe_step_in), .strobe_valid_in(strobe_valid_in), .seq_clear_in(seq_clear_in),
  .write_refused_out(write_refused_out), .nv_loaded_out(nv_loaded_out),
  .backup_step_allowed_out(backup_step_allowed_out),
  .low_voltage_load_switch_en_out(low_voltage_load_switch_en_out),
  .first_general_output_en_out(first_general_output_en_out), .controlled_out(controlled_out));

/* verification/rss_regs_tb.sv */
// Testbench of the rail strobe assignment register block.
`timescale 1ns/10ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_fail++; $display("[ERR] %0t %h %h", $time, g, e); end end
module rss_regs_tb;
  import rss_pkg::*;
  logic clk_in, sys_rst_in, wr_in, rd_in, password_ok_in, factory_seal_flag_in, strobe_valid_in, seq_clear_in;
  logic write_refused_out, nv_loaded_out, backup_step_allowed_out, ok;
  logic [7:0] addr_in, wdata_in, rdata_out, nv_a, nv_g;
  logic [3:0] strobe_step_in, controlled_out, en, k;
  int n_fail = 0;
  int n_checks = 0;
  int cyc = 0;
  rss_regs uut (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
    .rd_in(rd_in), .rdata_out(rdata_out), .password_ok_in(password_ok_in), .nv_switch_ldo_in(nv_a),
    .nv_gpo_in(nv_g), .factory_seal_flag_in(factory_seal_flag_in), .strobe_step_in(strobe_step_in),
    .strobe_valid_in(strobe_valid_in), .seq_clear_in(seq_clear_in), .write_refused_out(write_refused_out),
    .nv_loaded_out(nv_loaded_out), .backup_step_allowed_out(backup_step_allowed_out),
    .low_voltage_load_switch_en_out(en[3]), .general_linear_regulator_en_out(en[2]),
    .third_general_output_en_out(en[1]), .first_general_output_en_out(en[0]), .controlled_out(controlled_out));
  initial
  begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  task results;
    $display("checks %0d fails %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge clk_in)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      n_fail++;
      results();
    end
  end
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
    #1;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 `CHK(rdata_out, e)
  endtask
  task step(input logic [3:0] s);
    @(posedge clk_in);
    strobe_step_in <= s;
    strobe_valid_in <= 1'b1;
    @(posedge clk_in);
    strobe_valid_in <= 1'b0;
    #1;
  endtask
  initial
  begin
    {wr_in, rd_in, password_ok_in, factory_seal_flag_in, strobe_valid_in, seq_clear_in} = 6'h00;
    {addr_in, wdata_in, strobe_step_in} = 20'h00000;
    nv_a = RSS_SWITCH_LDO_RESET;
    nv_g = RSS_GPO_RESET;
    sys_rst_in = 1'b1;
    repeat (12) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    for (int i = 0; i < 20 && nv_loaded_out !== 1'b1; i++) @(posedge clk_in);
    `CHK(nv_loaded_out, 1'b1)
    rd(RSS_SWITCH_LDO_ADDR, {4'ha, 4'h7});
    rd(8'h26, {4'h3, 4'h5});
    rd(8'h27, 8'h00);
    $display("test reset values done");
    wr(8'h26, 8'h00);
    `CHK(write_refused_out, 1'b1)
    rd(8'h26, 8'h35);
    password_ok_in <= 1'b1;
    $display("test password done");
    for (int c = 0; c < 16; c++)
    begin
      k = c[3:0];
      ok = (k >= 4'h3) && (k <= 4'ha);
      wr(RSS_SWITCH_LDO_ADDR, {k, k});
      wr(8'h26, {k, k});
      rd(8'h26, {k, k});
      rd(RSS_SWITCH_LDO_ADDR, {k, k});
      `CHK(controlled_out, {4{ok}})
      @(posedge clk_in);
      seq_clear_in <= 1'b1;
      @(posedge clk_in);
      seq_clear_in <= 1'b0;
      step(k + 4'h1);
      `CHK(en, 4'h0)
      step(k);
      `CHK(en, {4{ok}})
    end
    $display("test step codes done");
    @(posedge clk_in);
    nv_a <= 8'h5b;
    nv_g <= 8'h94;
    sys_rst_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    for (int i = 0; i < 20 && nv_loaded_out !== 1'b1; i++) @(posedge clk_in);
    `CHK(nv_loaded_out, 1'b1)
    `CHK(en, 4'h0)
    rd(RSS_SWITCH_LDO_ADDR, 8'h5b);
    rd(RSS_GPO_ADDR, 8'h94);
    $display("test nonvolatile load done");
    for (int s = 1; s < 4; s++)
    begin
      @(posedge clk_in);
      strobe_step_in <= s[3:0];
      strobe_valid_in <= 1'b1;
      @(posedge clk_in);
      #1 `CHK(backup_step_allowed_out, s < 3)
    end
    strobe_step_in <= 4'h1;
    factory_seal_flag_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    #1 `CHK(backup_step_allowed_out, 1'b0)
    $display("test backup steps done");
    results();
  end
endmodule
